// [lvsc_pkg.sv]
// Package for the low-voltage supervisor and stop control block.
// Assumes an 8-bit register port with one-cycle strobes and a 40 MHz clock.
package lvsc_pkg;
    localparam int unsigned ADDR_W = 2;
    localparam int unsigned DATA_W = 8;

    // Register offsets
    localparam logic [1:0] OFS_SUP_CTRL  = 2'h0;
    localparam logic [1:0] OFS_LVL_CTRL  = 2'h1;
    localparam logic [1:0] OFS_IRQ_STAT  = 2'h2;
    localparam logic [1:0] OFS_IRQ_MASK  = 2'h3;

    // Supervisor control/status fields
    localparam int unsigned B_WARN_FLAG  = 7;
    localparam int unsigned B_WARN_ACK   = 6;
    localparam int unsigned B_WARN_IE    = 5;
    localparam int unsigned B_DET_RE     = 4;
    localparam int unsigned B_DET_SE     = 3;
    localparam int unsigned B_DET_EN     = 2;
    localparam int unsigned B_BG_EN      = 0;

    // Level and stop control/status fields
    localparam int unsigned B_DET_VSEL   = 5;
    localparam int unsigned B_WARN_VSEL  = 4;
    localparam int unsigned B_DS_FLAG    = 3;
    localparam int unsigned B_DS_ACK     = 2;
    localparam int unsigned B_STOP_DEPTH = 0;

    // Interrupt status/mask fields
    localparam int unsigned B_EV_WARN    = 0;
    localparam int unsigned B_EV_DETECT  = 1;
    localparam int unsigned B_EV_DSTOP   = 2;
    localparam int unsigned EV_W         = 3;

    // Reset values
    localparam logic       RST_DET_EN    = 1'b1;
    localparam logic       RST_DET_RE    = 1'b1;
    localparam logic       RST_DET_SE    = 1'b0;
    localparam logic       RST_OTHER     = 1'b0;
    localparam logic [2:0] RST_EV        = 3'h0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } lvsc_bus_req_t;

    typedef struct packed {
        logic       det_enable;
        logic       det_reset_en;
        logic       det_stop_en;
        logic       warn_irq_en;
        logic       bg_enable;
        logic       det_vsel;
        logic       warn_vsel;
        logic       stop_depth;
    } lvsc_cfg_t;
endpackage

// [lvsc_top.sv]
// Low-voltage supervisor, trip level select and stop depth control.
// Comparator outputs and the deep-stop recovery pulse arrive asynchronously.
// How it works
// [R1] Warning flag sets and sticks until acknowledged
// [R2] Warning present at reset also sets flag
// [R3] Acknowledge clears flag only when warning gone
// [R4] Interrupt request while flag and enable set
// [R5] Enabled detect with reset enable forces reset
// [R6] Stop enable keeps detect alive in stop
// [R7] Detect enable gates reset and stop settings
// [R8] Bit zero drives bandgap buffer enable
// [R9] Write-once bits take first write only
// [R10] Detect select sets detect level, warning range
// [R11] Warning select picks level within range
// [R12] Two selects encode four warning levels
// [R13] Read-only flag shows deep stop recovery
// [R14] Acknowledge write clears deep stop flag
// [R15] Stop depth bit selects shallow or deep
// [R16] Software writes both registers at initialisation
// [R17] Comparator outputs synchronised before use
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/1ps
module lvsc_top
    import lvsc_pkg::*;
(
    input  wire logic                       CLK_SYS_I,
    input  wire logic                       RESET_N_I,
    input  wire lvsc_pkg::lvsc_bus_req_t    BUS_REQ_I,
    output logic [lvsc_pkg::DATA_W-1:0]     BUS_RDATA_O,
    input  wire logic                       WARN_CMP_I,
    input  wire logic                       DETECT_CMP_I,
    input  wire logic                       DEEP_STOP_WAKE_I,
    input  wire logic                       IN_STOP_I,
    output logic                            WARN_IRQ_REQ_O,
    output logic                            SYS_RESET_REQ_O,
    output logic                            DETECT_ACTIVE_O,
    output logic                            BANDGAP_BUF_EN_O,
    output logic [1:0]                      WARN_LEVEL_SEL_O,
    output logic                            DETECT_LEVEL_SEL_O,
    output logic                            DEEP_STOP_SEL_O,
    output logic                            IRQ_O
);
    import lvsc_pkg::*;

    // Reset release
    logic [1:0] rst_sync_reg;
    logic       rst_n;
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Input synchronisers: three stages, change taken when stages 2 and 3 agree
    localparam int unsigned N_IN = 3;
    logic [N_IN-1:0] in_raw;
    logic [N_IN-1:0] s1_reg, s2_reg, s3_reg;
    logic [N_IN-1:0] in_q_reg, in_q_next;
    assign in_raw = {DEEP_STOP_WAKE_I, DETECT_CMP_I, WARN_CMP_I};

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_sync
            always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
                if (!rst_n) begin
                    s1_reg[gi] <= 1'b0;
                    s2_reg[gi] <= 1'b0;
                    s3_reg[gi] <= 1'b0;
                end else begin
                    s1_reg[gi] <= in_raw[gi]; // R17
                    s2_reg[gi] <= s1_reg[gi];
                    s3_reg[gi] <= s2_reg[gi];
                end
            end
            always_comb begin
                in_q_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s2_reg[gi] : in_q_reg[gi]; // R17
            end
        end
    endgenerate

    logic warn_now, det_now, wake_now, wake_prev_reg;
    assign warn_now = in_q_reg[0];
    assign det_now  = in_q_reg[1];
    assign wake_now = in_q_reg[2];

    // Register write decode
    function automatic logic wr_hit(input lvsc_bus_req_t r, input logic [1:0] ofs);
        return r.wr && (r.addr == ofs);
    endfunction

    logic wr_sup, wr_lvl, wr_stat, wr_mask;
    assign wr_sup  = wr_hit(BUS_REQ_I, OFS_SUP_CTRL);
    assign wr_lvl  = wr_hit(BUS_REQ_I, OFS_LVL_CTRL);
    assign wr_stat = wr_hit(BUS_REQ_I, OFS_IRQ_STAT);
    assign wr_mask = wr_hit(BUS_REQ_I, OFS_IRQ_MASK);

    // Control state
    lvsc_cfg_t       cfg_reg, cfg_next;
    logic            lock_sup_reg, lock_sup_next;
    logic            lock_lvl_reg, lock_lvl_next;
    logic            warn_flag_reg, warn_flag_next;
    logic            ds_flag_reg, ds_flag_next;
    logic [EV_W-1:0] ev_stat_reg, ev_stat_next;
    logic [EV_W-1:0] ev_mask_reg, ev_mask_next;
    logic            det_live;
    logic            det_event;
    logic            wake_rise;
    logic [DATA_W-1:0] wd;

    assign wd = BUS_REQ_I.wdata;

    // Detect runs when enabled, and in stop only with stop enable
    assign det_live  = cfg_reg.det_enable && (!IN_STOP_I || cfg_reg.det_stop_en); // R6 R7
    assign det_event = det_live && det_now;
    assign wake_rise = wake_now && !wake_prev_reg;

    always_comb begin
        cfg_next      = cfg_reg;
        lock_sup_next = lock_sup_reg;
        lock_lvl_next = lock_lvl_reg;

        if (wr_sup) begin
            cfg_next.warn_irq_en = wd[B_WARN_IE];
            cfg_next.det_stop_en = wd[B_DET_SE];
            cfg_next.bg_enable   = wd[B_BG_EN]; // R8
            if (!lock_sup_reg) begin // R9
                cfg_next.det_reset_en = wd[B_DET_RE];
                cfg_next.det_enable   = wd[B_DET_EN];
                lock_sup_next         = 1'b1;
            end
        end
        if (wr_lvl) begin
            cfg_next.warn_vsel = wd[B_WARN_VSEL]; // R11
            if (!lock_lvl_reg) begin // R9
                cfg_next.det_vsel   = wd[B_DET_VSEL]; // R10
                cfg_next.stop_depth = wd[B_STOP_DEPTH]; // R15
                lock_lvl_next       = 1'b1;
            end
        end
    end

    // Flags: a set in the same cycle as a clear wins
    always_comb begin
        warn_flag_next = warn_flag_reg;
        ds_flag_next   = ds_flag_reg;
        if (wr_sup && wd[B_WARN_ACK] && !warn_now) begin // R3
            warn_flag_next = 1'b0;
        end
        if (warn_now) begin // R1 R2
            warn_flag_next = 1'b1;
        end
        if (wr_lvl && wd[B_DS_ACK]) begin // R14
            ds_flag_next = 1'b0;
        end
        if (wake_rise) begin // R13
            ds_flag_next = 1'b1;
        end
    end

    // Interrupt status: write one to clear, new events win
    logic [EV_W-1:0] ev_set;
    always_comb begin
        ev_set              = '0;
        ev_set[B_EV_WARN]   = warn_now && !warn_flag_reg;
        ev_set[B_EV_DETECT] = det_event;
        ev_set[B_EV_DSTOP]  = wake_rise;
        ev_stat_next        = ev_stat_reg;
        ev_mask_next        = ev_mask_reg;
        if (wr_stat) begin
            ev_stat_next = ev_stat_reg & ~wd[EV_W-1:0];
        end
        ev_stat_next = ev_stat_next | ev_set;
        if (wr_mask) begin
            ev_mask_next = wd[EV_W-1:0];
        end
    end

    // Read mux
    logic [DATA_W-1:0] rdata_next, rdata_reg;
    always_comb begin
        rdata_next = '0;
        if (BUS_REQ_I.rd) begin
            unique case (BUS_REQ_I.addr)
                OFS_SUP_CTRL: begin
                    rdata_next[B_WARN_FLAG] = warn_flag_reg;
                    rdata_next[B_WARN_IE]   = cfg_reg.warn_irq_en;
                    rdata_next[B_DET_RE]    = cfg_reg.det_reset_en;
                    rdata_next[B_DET_SE]    = cfg_reg.det_stop_en;
                    rdata_next[B_DET_EN]    = cfg_reg.det_enable;
                    rdata_next[B_BG_EN]     = cfg_reg.bg_enable;
                end
                OFS_LVL_CTRL: begin
                    rdata_next[B_DET_VSEL]   = cfg_reg.det_vsel;
                    rdata_next[B_WARN_VSEL]  = cfg_reg.warn_vsel;
                    rdata_next[B_DS_FLAG]    = ds_flag_reg;
                    rdata_next[B_STOP_DEPTH] = cfg_reg.stop_depth;
                end
                OFS_IRQ_STAT: rdata_next[EV_W-1:0] = ev_stat_reg;
                OFS_IRQ_MASK: rdata_next[EV_W-1:0] = ev_mask_reg;
            endcase
        end
    end

    // Output next values
    logic       irq_req_next, rst_req_next, irq_next;
    logic [1:0] warn_lvl_next;
    always_comb begin
        irq_req_next  = cfg_next.warn_irq_en && warn_flag_next; // R4
        // Reset request only counts when detection is enabled
        rst_req_next  = det_event && cfg_reg.det_reset_en; // R5 R7
        // Code {detect, warning}: detect bit alone picks the detect level
        warn_lvl_next = {cfg_next.det_vsel, cfg_next.warn_vsel}; // R12
        irq_next      = |(ev_stat_next & ev_mask_next);
    end

    always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
            in_q_reg           <= '0;
            wake_prev_reg      <= 1'b0;
            cfg_reg.det_enable   <= RST_DET_EN;
            cfg_reg.det_reset_en <= RST_DET_RE;
            cfg_reg.det_stop_en  <= RST_DET_SE;
            cfg_reg.warn_irq_en  <= RST_OTHER;
            cfg_reg.bg_enable    <= RST_OTHER;
            cfg_reg.det_vsel     <= RST_OTHER;
            cfg_reg.warn_vsel    <= RST_OTHER;
            cfg_reg.stop_depth   <= RST_OTHER;
            lock_sup_reg       <= 1'b0;
            lock_lvl_reg       <= 1'b0;
            warn_flag_reg      <= 1'b0;
            ds_flag_reg        <= 1'b0;
            ev_stat_reg        <= RST_EV;
            ev_mask_reg        <= RST_EV;
            rdata_reg          <= '0;
            WARN_IRQ_REQ_O     <= 1'b0;
            SYS_RESET_REQ_O    <= 1'b0;
            DETECT_ACTIVE_O    <= 1'b0;
            BANDGAP_BUF_EN_O   <= 1'b0;
            WARN_LEVEL_SEL_O   <= 2'h0;
            DETECT_LEVEL_SEL_O <= 1'b0;
            DEEP_STOP_SEL_O    <= 1'b0;
            IRQ_O              <= 1'b0;
        end else begin
            in_q_reg           <= in_q_next;
            wake_prev_reg      <= wake_now;
            cfg_reg            <= cfg_next;
            lock_sup_reg       <= lock_sup_next;
            lock_lvl_reg       <= lock_lvl_next;
            warn_flag_reg      <= warn_flag_next;
            ds_flag_reg        <= ds_flag_next;
            ev_stat_reg        <= ev_stat_next;
            ev_mask_reg        <= ev_mask_next;
            rdata_reg          <= rdata_next;
            WARN_IRQ_REQ_O     <= irq_req_next;
            SYS_RESET_REQ_O    <= rst_req_next;
            DETECT_ACTIVE_O    <= cfg_next.det_enable
                                  && (!IN_STOP_I || cfg_next.det_stop_en); // R6 R7
            BANDGAP_BUF_EN_O   <= cfg_next.bg_enable; // R8
            WARN_LEVEL_SEL_O   <= warn_lvl_next; // R11 R12
            DETECT_LEVEL_SEL_O <= cfg_next.det_vsel; // R10
            DEEP_STOP_SEL_O    <= cfg_next.stop_depth; // R15
            IRQ_O              <= irq_next;
        end
    end

    assign BUS_RDATA_O = rdata_reg;
endmodule

// [lvsc_chk.sv]
// Port-level checker for the supervisor block.
// Assumes outputs settle within five edges of reset release.
`timescale 1ns/1ps
module lvsc_chk
    import lvsc_pkg::*;
(
    input wire logic                   CLK_SYS_I,
    input wire logic                   RESET_N_I,
    input wire lvsc_pkg::lvsc_bus_req_t BUS_REQ_I,
    input wire logic [7:0]             BUS_RDATA_O,
    input wire logic                   IN_STOP_I,
    input wire logic                   WARN_IRQ_REQ_O,
    input wire logic                   SYS_RESET_REQ_O,
    input wire logic                   DETECT_ACTIVE_O,
    input wire logic                   BANDGAP_BUF_EN_O,
    input wire logic [1:0]             WARN_LEVEL_SEL_O,
    input wire logic                   DETECT_LEVEL_SEL_O,
    input wire logic                   DEEP_STOP_SEL_O
);
    logic [2:0] up_reg;
    logic       lvl_seen_reg;
    wire        ok     = up_reg == 3'h5;
    wire        wr_sup = BUS_REQ_I.wr && BUS_REQ_I.addr == OFS_SUP_CTRL;
    wire        wr_lvl = BUS_REQ_I.wr && BUS_REQ_I.addr == OFS_LVL_CTRL;
    wire        rd_sup = BUS_REQ_I.rd && BUS_REQ_I.addr == OFS_SUP_CTRL;
    // Outputs still move while the internal reset copy drains
    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            up_reg       <= 3'h0;
            lvl_seen_reg <= 1'b0;
        end else begin
            up_reg       <= ok ? up_reg : up_reg + 3'h1;
            lvl_seen_reg <= lvl_seen_reg | wr_lvl;
        end
    end
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);
    property p_rd_idle; ok && !$past(BUS_REQ_I.rd) |-> BUS_RDATA_O == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_irq_req; ok && $past(rd_sup) && BUS_RDATA_O[7] && BUS_RDATA_O[5]
        |-> WARN_IRQ_REQ_O || $past(WARN_IRQ_REQ_O); endproperty
    a_irq_req: assert property (p_irq_req) else $error("warning request missing");
    property p_sys_rst; SYS_RESET_REQ_O |-> DETECT_ACTIVE_O || $past(DETECT_ACTIVE_O); endproperty
    a_sys_rst: assert property (p_sys_rst) else $error("reset without live detect");
    property p_act; ok && $changed(DETECT_ACTIVE_O)
        |-> $past(BUS_REQ_I.wr) || $past(IN_STOP_I) != $past(IN_STOP_I, 2); endproperty
    a_act: assert property (p_act) else $error("detect active moved alone");
    property p_bg; ok && wr_sup |=> BANDGAP_BUF_EN_O == $past(BUS_REQ_I.wdata[0]); endproperty
    a_bg: assert property (p_bg) else $error("bandgap enable wrong");
    property p_hold; ok && !$past(BUS_REQ_I.wr) |-> $stable(BANDGAP_BUF_EN_O)
        && $stable(WARN_LEVEL_SEL_O) && $stable(DEEP_STOP_SEL_O); endproperty
    a_hold: assert property (p_hold) else $error("control moved without write");
    property p_lock; ok && lvl_seen_reg && wr_lvl
        |=> $stable(DEEP_STOP_SEL_O) && $stable(DETECT_LEVEL_SEL_O); endproperty
    a_lock: assert property (p_lock) else $error("write-once bit changed");
    property p_lvl; WARN_LEVEL_SEL_O[1] == DETECT_LEVEL_SEL_O; endproperty
    a_lvl: assert property (p_lvl) else $error("level code range wrong");
endmodule
bind lvsc_top lvsc_chk i_lvsc_chk (
    .CLK_SYS_I, .RESET_N_I, .BUS_REQ_I, .BUS_RDATA_O, .IN_STOP_I, .WARN_IRQ_REQ_O,
    .SYS_RESET_REQ_O, .DETECT_ACTIVE_O, .BANDGAP_BUF_EN_O, .WARN_LEVEL_SEL_O,
    .DETECT_LEVEL_SEL_O, .DEEP_STOP_SEL_O
);

// [tb_lvsc_top.sv]
// Self-checking bench: register port, comparator inputs, stop and wake.
// Assumes async inputs reach the flags within eight cycles.
`timescale 1ns/1ps
module tb_lvsc_top;
    import lvsc_pkg::*;
    logic          clk = 1'b0;
    logic          rst_n = 1'b0;
    lvsc_bus_req_t req = '0;
    logic          warn = 1'b1, det = 1'b0, wake = 1'b0, stp = 1'b0;
    logic [7:0]    rdata, d;
    logic [1:0]    lvl_sel;
    logic          w_irq, s_rst, act, bg, d_sel, ds_sel, irq;
    int            bad_count = 0, n_checks = 0, cyc = 0;
    always #12.5 clk = ~clk;
    lvsc_top i_lvsc_top (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .BUS_REQ_I(req),
        .BUS_RDATA_O(rdata), .WARN_CMP_I(warn), .DETECT_CMP_I(det),
        .DEEP_STOP_WAKE_I(wake), .IN_STOP_I(stp), .WARN_IRQ_REQ_O(w_irq),
        .SYS_RESET_REQ_O(s_rst), .DETECT_ACTIVE_O(act), .BANDGAP_BUF_EN_O(bg),
        .WARN_LEVEL_SEL_O(lvl_sel), .DETECT_LEVEL_SEL_O(d_sel),
        .DEEP_STOP_SEL_O(ds_sel), .IRQ_O(irq));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic conclude();
        if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        tick(1);
        req.wr <= 1'b0;
        tick(1);
    endtask
    // Unlisted bits are left out of the compare
    task automatic rchk(input string nm, input logic [1:0] a, input logic [7:0] e);
        logic [7:0] m;
        m = (a == OFS_SUP_CTRL) ? 8'hfd : (a == OFS_LVL_CTRL) ? 8'h3d : 8'h07;
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        tick(1);
        req.rd <= 1'b0;
        #1 chk(nm, e & m, rdata & m);
        tick(1);
    endtask
    function automatic logic [7:0] sup_exp(input logic f, input logic [7:0] v);
        return {f, 1'b0, v[5], 1'b1, v[3], 1'b1, 1'b0, v[0]};
    endfunction
    task automatic lvl(input logic [7:0] v, input logic [1:0] lk, input logic f);
        wr(OFS_LVL_CTRL, v);
        #1 chk("lvl_sel", {6'h0, lk[1], v[4]}, {6'h0, lvl_sel});
        chk("depth", {7'h0, lk[0]}, {7'h0, ds_sel});
        chk("det_sel", {7'h0, lk[1]}, {7'h0, d_sel});
        rchk("lvl_reg", OFS_LVL_CTRL, {2'h0, lk[1], v[4], f, 2'h0, lk[0]});
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            conclude();
        end
    end
    initial begin
        void'($urandom(80));
        tick(2);
        rst_n <= 1'b1;
        tick(11);
        rchk("sup_rst", OFS_SUP_CTRL, 8'h94);
        rchk("lvl_rst", OFS_LVL_CTRL, 8'h00);
        rchk("stat_warn", OFS_IRQ_STAT, 8'h01);
        wr(OFS_IRQ_STAT, 8'h07);
        wr(OFS_SUP_CTRL, 8'h74);
        rchk("ack_busy", OFS_SUP_CTRL, 8'hb4);
        #1 chk("warn_irq", 8'h01, {7'h0, w_irq});
        warn <= 1'b0;
        tick(8);
        rchk("sticky", OFS_SUP_CTRL, 8'hb4);
        wr(OFS_SUP_CTRL, 8'h40);
        rchk("acked", OFS_SUP_CTRL, 8'h14);
        #1 chk("irq_off", 8'h00, {7'h0, w_irq});
        stp <= 1'b1;
        tick(3);
        #1 chk("act_stop", 8'h00, {7'h0, act});
        wr(OFS_SUP_CTRL, 8'h08);
        #1 chk("act_se", 8'h01, {7'h0, act});
        stp <= 1'b0;
        det <= 1'b1;
        tick(8);
        #1 chk("sys_rst", 8'h01, {7'h0, s_rst});
        rchk("stat_det", OFS_IRQ_STAT, 8'h02);
        wr(OFS_IRQ_MASK, 8'h02);
        tick(1);
        #1 chk("irq_on", 8'h01, {7'h0, irq});
        wr(OFS_IRQ_MASK, 8'h00);
        tick(1);
        #1 chk("irq_mask", 8'h00, {7'h0, irq});
        det <= 1'b0;
        tick(8);
        wr(OFS_IRQ_STAT, 8'h02);
        rchk("stat_clr", OFS_IRQ_STAT, 8'h00);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom()) & 8'h29;
            wr(OFS_SUP_CTRL, d);
            #1 chk("bg", {7'h0, d[0]}, {7'h0, bg});
            rchk("sup_rnd", OFS_SUP_CTRL, sup_exp(1'b0, d));
        end
        lvl(8'h00, 2'h0, 1'b0);
        for (int i = 0; i < 4; i++) lvl(8'($urandom()) & 8'h31, 2'h0, 1'b0);
        rst_n <= 1'b0;
        tick(2);
        rst_n <= 1'b1;
        tick(3);
        wr(OFS_SUP_CTRL, 8'h00);
        det <= 1'b1;
        tick(8);
        #1 chk("no_rst", 8'h00, {7'h0, s_rst});
        chk("no_act", 8'h00, {7'h0, act});
        det <= 1'b0;
        lvl(8'h31, 2'h3, 1'b0);
        lvl(8'h00, 2'h3, 1'b0);
        wake <= 1'b1;
        tick(8);
        rchk("ds_flag", OFS_LVL_CTRL, 8'h29);
        rchk("stat_ds", OFS_IRQ_STAT, 8'h04);
        wake <= 1'b0;
        wr(OFS_LVL_CTRL, 8'h04);
        rchk("ds_ack", OFS_LVL_CTRL, 8'h21);
        conclude();
    end
endmodule
